// file: design/sync_params_bank.sv
// Sync manager timing parameter bank with Wishbone slave and per-side timing monitors
// What this block does
// RULE_01: Input sync mode encodes 0,1,2,3,34; default 34
// RULE_02: Output supported-modes word carries fixed capability bits
// RULE_03: Input supported-modes word defaults to 0xC007
// RULE_04: Command 1 starts, 0 stops measurement
// RULE_05: Measuring updates timing entries with maximum values
// RULE_06: New measurement clears previous maximum values first
// RULE_07: Minimum cycle time is read-only, resets zero
// RULE_08: Output calc time: SYNC0 to SYNC1 minimum
// RULE_09: Output delay: SYNC1 until outputs driven
// RULE_10: Count missed SM events in operational DC
// RULE_11: Count late or early cycles while operational
// RULE_12: Count SYNC0 to SYNC1 spacing too short
// RULE_13: Sync error flag when outputs driven late
// RULE_14: Input shift: SYNC0 until inputs sampled
// RULE_15: Input calc time: sampling until data available
// RULE_16: Input delay: SYNC1 until inputs sampled
// RULE_17: Input group reports highest subindex 0x20
// RULE_18: Cycle time in ns, meaning per mode
// RULE_19: Input counters and flag mirror output ones
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "sync_params_defs.svh"

module sync_side #(
  parameter bit IS_INPUT = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Timing events, one-cycle pulses
  input wire logic sync0,
  input wire logic sync1,
  input wire logic sm_event,
  input wire logic act_pulse,
  input wire logic ready_pulse,
  input wire logic cycle_start,
  input wire logic cycle_done,
  // Control
  input wire logic op_state,
  input wire logic dc_mode,
  input wire logic [31:0] cycle_time,
  input wire logic measuring,
  input wire logic meas_start,
  input wire logic [31:0] now_ns,
  // Results
  output logic [31:0] shift_time,
  output logic [31:0] calc_copy_time,
  output logic [31:0] delay_time,
  output logic [31:0] min_cycle_time,
  output logic [15:0] missed_count,
  output logic [15:0] exceeded_count,
  output logic [15:0] short_count,
  output logic sync_err,
  output sync_params_pkg::side_events_t events
);
  logic [31:0] t_sync0_reg, t_sync1_reg, t_act_reg, t_cyc_reg;
  logic seen_sm_reg, seen_act_reg, seen_ready_reg, had_sync0_reg, busy_reg, overrun_reg;
  wire [31:0] d_shift = now_ns - t_sync0_reg;
  wire [31:0] d_calc = IS_INPUT ? now_ns - t_act_reg : now_ns - t_sync0_reg;
  wire [31:0] d_delay = now_ns - t_sync1_reg;
  wire [31:0] d_cyc = now_ns - t_cyc_reg;
  wire upd = measuring && !meas_start;
  // Missed and sync-error checks need one full cycle behind them
  wire miss_ev = sync0 && dc_mode && op_state && had_sync0_reg && !seen_sm_reg; // [RULE_10] [RULE_19]
  wire late_ev = busy_reg && !overrun_reg && cycle_time != `RST_TIME && d_cyc > cycle_time;
  wire exceed_ev = op_state && ((cycle_start && busy_reg) || late_ev); // [RULE_11] [RULE_19]
  wire short_ev = sync1 && dc_mode && !seen_ready_reg; // [RULE_12] [RULE_19]
  wire err_ev = sync0 && dc_mode && had_sync0_reg && !seen_act_reg; // [RULE_13] [RULE_19]

  assign events = {err_ev, short_ev, exceed_ev, miss_ev};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      t_sync0_reg <= `RST_TIME;
      t_sync1_reg <= `RST_TIME;
      t_act_reg <= `RST_TIME;
      t_cyc_reg <= `RST_TIME;
    end else begin
      if (sync0) t_sync0_reg <= now_ns;
      if (sync1) t_sync1_reg <= now_ns;
      if (act_pulse) t_act_reg <= now_ns;
      if (cycle_start) t_cyc_reg <= now_ns;
    end
  end

  // A mark that arrives with the sync0 that clears it belongs to the new cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seen_sm_reg <= 1'b0;
      seen_act_reg <= 1'b0;
      seen_ready_reg <= 1'b0;
      had_sync0_reg <= 1'b0;
      busy_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      seen_sm_reg <= sm_event || (seen_sm_reg && !sync0);
      seen_act_reg <= act_pulse || (seen_act_reg && !sync0);
      seen_ready_reg <= ready_pulse || (seen_ready_reg && !sync0);
      had_sync0_reg <= had_sync0_reg || sync0;
      busy_reg <= cycle_start || (busy_reg && !cycle_done);
      overrun_reg <= !cycle_start && (overrun_reg || late_ev);
    end
  end

  // Maximum capture; start clears before accumulating
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shift_time <= `RST_TIME;
      calc_copy_time <= `RST_TIME;
      delay_time <= `RST_TIME;
      min_cycle_time <= `RST_TIME;
    end else if (meas_start) begin
      shift_time <= `RST_TIME; // [RULE_06]
      calc_copy_time <= `RST_TIME;
      delay_time <= `RST_TIME;
      min_cycle_time <= `RST_TIME;
    end else if (upd) begin
      if (act_pulse && d_shift > shift_time) shift_time <= d_shift; // [RULE_05] [RULE_14]
      if (ready_pulse && d_calc > calc_copy_time) calc_copy_time <= d_calc; // [RULE_08] [RULE_15]
      if (act_pulse && d_delay > delay_time) delay_time <= d_delay; // [RULE_09] [RULE_16]
      if (cycle_done && busy_reg && d_cyc > min_cycle_time) min_cycle_time <= d_cyc; // [RULE_07]
    end
  end

  // Counters saturate rather than wrap so a reader never sees a small count after a storm
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      missed_count <= `RST_COUNT;
      exceeded_count <= `RST_COUNT;
      short_count <= `RST_COUNT;
      sync_err <= 1'b0;
    end else begin
      if (miss_ev && missed_count != 16'hffff) missed_count <= missed_count + 16'h0001;
      if (exceed_ev && exceeded_count != 16'hffff) exceeded_count <= exceeded_count + 16'h0001;
      if (short_ev && short_count != 16'hffff) short_count <= short_count + 16'h0001;
      if (!dc_mode) sync_err <= 1'b0;
      else if (sync0 && had_sync0_reg) sync_err <= !seen_act_reg; // [RULE_13]
    end
  end
endmodule

module sync_params_bank (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Distributed clock and state
  input wire logic sync0_evt,
  input wire logic sync1_evt,
  input wire logic op_state,
  // Output side events
  input wire logic out_sm_evt,
  input wire logic outputs_driven,
  input wire logic out_data_ready,
  input wire logic out_cycle_start,
  input wire logic out_cycle_done,
  // Input side events
  input wire logic in_sm_evt,
  input wire logic inputs_sampled,
  input wire logic in_data_ready,
  input wire logic in_cycle_start,
  input wire logic in_cycle_done,
  // Status
  output logic measure_active,
  output logic out_dc_mode,
  output logic in_dc_mode,
  output logic irq
);
  logic ack_reg;
  logic [31:0] rdata_reg, now_ns_reg;
  logic [15:0] out_sync_mode_reg, in_sync_mode_reg;
  logic [31:0] out_cycle_time_reg, in_cycle_time_reg;
  logic measuring_reg;
  logic [7:0] irq_status_reg, irq_mask_reg;
  logic [31:0] o_shift, o_calc, o_delay, o_min, i_shift, i_calc, i_delay, i_min;
  logic [15:0] o_miss, o_exc, o_short, i_miss, i_exc, i_short;
  logic o_err, i_err;
  sync_params_pkg::side_events_t o_ev, i_ev;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // Bus decode: request cycle, then ack cycle at whose edge writes land
  wire req = wb_cyc_i && wb_stb_i;
  wire wr = req && wb_we_i && ack_reg;
  wire rd_done = req && !wb_we_i && ack_reg;
  wire wr_out_mode = wr && wb_adr_i == `OFF_OUT_SYNC_MODE;
  wire wr_in_mode = wr && wb_adr_i == `OFF_IN_SYNC_MODE;
  wire wr_out_cyc = wr && wb_adr_i == `OFF_OUT_CYCLE_TIME;
  wire wr_in_cyc = wr && wb_adr_i == `OFF_IN_CYCLE_TIME;
  wire wr_cmd = wr && (wb_adr_i == `OFF_OUT_COMMAND || wb_adr_i == `OFF_IN_COMMAND);
  wire wr_mask = wr && wb_adr_i == `OFF_IRQ_MASK;
  wire rd_status = rd_done && wb_adr_i == `OFF_IRQ_STATUS;
  wire [31:0] m_out_mode = merge({16'h0000, out_sync_mode_reg}, wb_dat_i, wb_sel_i);
  wire [31:0] m_in_mode = merge({16'h0000, in_sync_mode_reg}, wb_dat_i, wb_sel_i);
  wire [31:0] m_cmd = merge({16'h0000, 15'h0000, measuring_reg}, wb_dat_i, wb_sel_i);
  wire [31:0] m_mask = merge({24'h000000, irq_mask_reg}, wb_dat_i, wb_sel_i);
  // Unsupported mode codes are dropped so the mode always decodes
  wire out_mode_ok = m_out_mode[15:0] <= sync_params_pkg::MODE_DC_SYNC1;
  wire in_mode_ok = m_in_mode[15:0] <= sync_params_pkg::MODE_DC_SYNC1 ||
                    m_in_mode[15:0] == sync_params_pkg::MODE_OUT_SM_EVENT; // [RULE_01]
  wire meas_start = wr_cmd && m_cmd[15:0] == `CMD_START; // [RULE_04]
  wire meas_stop = wr_cmd && m_cmd[15:0] == `CMD_STOP;
  wire [7:0] ev_set = {i_ev, o_ev};
  wire [7:0] ev_clr = rd_status ? rdata_reg[7:0] : 8'h00;

  assign out_dc_mode = out_sync_mode_reg == sync_params_pkg::MODE_DC_SYNC0 ||
                       out_sync_mode_reg == sync_params_pkg::MODE_DC_SYNC1;
  assign in_dc_mode = in_sync_mode_reg == sync_params_pkg::MODE_DC_SYNC0 ||
                      in_sync_mode_reg == sync_params_pkg::MODE_DC_SYNC1;
  assign measure_active = measuring_reg;
  assign irq = |(irq_status_reg & irq_mask_reg);
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // Read selection; unmapped offsets answer zero
  wire [31:0] rsel =
    wb_adr_i == `OFF_OUT_SYNC_MODE ? {16'h0000, out_sync_mode_reg} :
    wb_adr_i == `OFF_OUT_CYCLE_TIME ? out_cycle_time_reg : // [RULE_18]
    wb_adr_i == `OFF_OUT_SHIFT_TIME ? o_shift :
    wb_adr_i == `OFF_OUT_SUPPORTED ? {16'h0000, `RST_SUPPORTED} : // [RULE_02]
    wb_adr_i == `OFF_OUT_MIN_CYCLE ? o_min :
    wb_adr_i == `OFF_OUT_CALC_COPY ? o_calc :
    wb_adr_i == `OFF_OUT_COMMAND ? {31'h0000_0000, measuring_reg} :
    wb_adr_i == `OFF_OUT_DELAY ? o_delay :
    wb_adr_i == `OFF_OUT_MISSED ? {16'h0000, o_miss} :
    wb_adr_i == `OFF_OUT_EXCEEDED ? {16'h0000, o_exc} :
    wb_adr_i == `OFF_OUT_SHORT ? {16'h0000, o_short} :
    wb_adr_i == `OFF_OUT_SYNC_ERR ? {31'h0000_0000, o_err} :
    wb_adr_i == `OFF_OUT_MAX_SUB ? {24'h000000, `RST_MAX_SUBINDEX} :
    wb_adr_i == `OFF_IN_MAX_SUB ? {24'h000000, `RST_MAX_SUBINDEX} : // [RULE_17]
    wb_adr_i == `OFF_IN_SYNC_MODE ? {16'h0000, in_sync_mode_reg} :
    wb_adr_i == `OFF_IN_CYCLE_TIME ? in_cycle_time_reg :
    wb_adr_i == `OFF_IN_SHIFT_TIME ? i_shift :
    wb_adr_i == `OFF_IN_SUPPORTED ? {16'h0000, `RST_SUPPORTED} : // [RULE_03]
    wb_adr_i == `OFF_IN_MIN_CYCLE ? i_min :
    wb_adr_i == `OFF_IN_CALC_COPY ? i_calc :
    wb_adr_i == `OFF_IN_COMMAND ? {31'h0000_0000, measuring_reg} :
    wb_adr_i == `OFF_IN_DELAY ? i_delay :
    wb_adr_i == `OFF_IN_MISSED ? {16'h0000, i_miss} :
    wb_adr_i == `OFF_IN_EXCEEDED ? {16'h0000, i_exc} :
    wb_adr_i == `OFF_IN_SHORT ? {16'h0000, i_short} :
    wb_adr_i == `OFF_IN_SYNC_ERR ? {31'h0000_0000, i_err} :
    wb_adr_i == `OFF_IRQ_STATUS ? {24'h000000, irq_status_reg} :
    wb_adr_i == `OFF_IRQ_MASK ? {24'h000000, irq_mask_reg} : 32'h0000_0000;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      now_ns_reg <= `RST_TIME;
    end else begin
      ack_reg <= req && !ack_reg;
      if (req && !ack_reg) rdata_reg <= wb_we_i ? 32'h0000_0000 : rsel;
      now_ns_reg <= now_ns_reg + `CLK_PERIOD_NS;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_sync_mode_reg <= `RST_OUT_SYNC_MODE;
      in_sync_mode_reg <= `RST_IN_SYNC_MODE; // [RULE_01]
      out_cycle_time_reg <= `RST_TIME;
      in_cycle_time_reg <= `RST_TIME;
      measuring_reg <= 1'b0;
      irq_mask_reg <= `RST_IRQ_MASK;
    end else begin
      if (wr_out_mode && out_mode_ok) out_sync_mode_reg <= m_out_mode[15:0];
      if (wr_in_mode && in_mode_ok) in_sync_mode_reg <= m_in_mode[15:0];
      if (wr_out_cyc) out_cycle_time_reg <= merge(out_cycle_time_reg, wb_dat_i, wb_sel_i);
      if (wr_in_cyc) in_cycle_time_reg <= merge(in_cycle_time_reg, wb_dat_i, wb_sel_i);
      if (meas_start) measuring_reg <= 1'b1; // [RULE_04]
      else if (meas_stop) measuring_reg <= 1'b0;
      if (wr_mask) irq_mask_reg <= m_mask[7:0];
    end
  end

  // Only bits that the read returned are cleared, and a new event wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) irq_status_reg <= 8'h00;
    else irq_status_reg <= (irq_status_reg & ~ev_clr) | ev_set;
  end

  sync_side #(.IS_INPUT(1'b0)) u_out (
    .clk(clk), .rstn(rstn), .sync0(sync0_evt), .sync1(sync1_evt), .sm_event(out_sm_evt),
    .act_pulse(outputs_driven), .ready_pulse(out_data_ready),
    .cycle_start(out_cycle_start), .cycle_done(out_cycle_done), .op_state(op_state),
    .dc_mode(out_dc_mode), .cycle_time(out_cycle_time_reg), .measuring(measuring_reg),
    .meas_start(meas_start), .now_ns(now_ns_reg), .shift_time(o_shift),
    .calc_copy_time(o_calc), .delay_time(o_delay), .min_cycle_time(o_min),
    .missed_count(o_miss), .exceeded_count(o_exc), .short_count(o_short),
    .sync_err(o_err), .events(o_ev)
  );

  sync_side #(.IS_INPUT(1'b1)) u_in (
    .clk(clk), .rstn(rstn), .sync0(sync0_evt), .sync1(sync1_evt), .sm_event(in_sm_evt),
    .act_pulse(inputs_sampled), .ready_pulse(in_data_ready),
    .cycle_start(in_cycle_start), .cycle_done(in_cycle_done), .op_state(op_state),
    .dc_mode(in_dc_mode), .cycle_time(in_cycle_time_reg), .measuring(measuring_reg),
    .meas_start(meas_start), .now_ns(now_ns_reg), .shift_time(i_shift),
    .calc_copy_time(i_calc), .delay_time(i_delay), .min_cycle_time(i_min),
    .missed_count(i_miss), .exceeded_count(i_exc), .short_count(i_short),
    .sync_err(i_err), .events(i_ev)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_in_mode_legal;
    in_sync_mode_reg inside {16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0022};
  endproperty
  a_in_mode_legal: assert property (p_in_mode_legal) else $error("Illegal input mode"); // [RULE_01]

  property p_out_supported_read;
    req && !ack_reg && !wb_we_i && wb_adr_i == `OFF_OUT_SUPPORTED
      |=> wb_ack_o && wb_dat_o == 32'h0000_c007;
  endproperty
  a_out_supported_read: assert property (p_out_supported_read) else $error("Bad out caps"); // [RULE_02]

  property p_in_supported_read;
    req && !ack_reg && !wb_we_i && wb_adr_i == `OFF_IN_SUPPORTED
      |=> wb_ack_o && wb_dat_o == 32'h0000_c007;
  endproperty
  a_in_supported_read: assert property (p_in_supported_read) else $error("Bad in caps"); // [RULE_03]

  property p_measure_cmd;
    (meas_start |=> measuring_reg) and (meas_stop |=> !measuring_reg);
  endproperty
  a_measure_cmd: assert property (p_measure_cmd) else $error("Command not obeyed"); // [RULE_04]

  property p_max_grows;
    measuring_reg && !meas_start |=> o_min >= $past(o_min) && i_shift >= $past(i_shift);
  endproperty
  a_max_grows: assert property (p_max_grows) else $error("Maximum decreased"); // [RULE_05]

  property p_start_clears;
    meas_start |=> o_shift == 32'h0 && o_calc == 32'h0 && i_delay == 32'h0 && i_min == 32'h0;
  endproperty
  a_start_clears: assert property (p_start_clears) else $error("Maxima not cleared"); // [RULE_06]

  property p_missed_count;
    $changed(o_miss) |-> $past(op_state) && $past(out_dc_mode) && $past(sync0_evt)
      && o_miss == $past(o_miss) + 16'h0001;
  endproperty
  a_missed_count: assert property (p_missed_count) else $error("Missed count bad"); // [RULE_10]

  property p_exceeded_count;
    $changed(i_exc) |-> $past(op_state) && i_exc == $past(i_exc) + 16'h0001;
  endproperty
  a_exceeded_count: assert property (p_exceeded_count) else $error("Exceeded bad"); // [RULE_11]

  property p_short_count;
    $changed(o_short) |-> $past(sync1_evt) && $past(out_dc_mode);
  endproperty
  a_short_count: assert property (p_short_count) else $error("Short count bad"); // [RULE_12]

  property p_err_rise;
    $rose(o_err) |-> $past(sync0_evt) && $past(out_dc_mode);
  endproperty
  a_err_rise: assert property (p_err_rise) else $error("Sync error rose wrongly"); // [RULE_13]

  property p_max_sub_read;
    req && !ack_reg && !wb_we_i && wb_adr_i == `OFF_IN_MAX_SUB
      |=> wb_ack_o && wb_dat_o == 32'h0000_0020 ##1 !wb_ack_o;
  endproperty
  a_max_sub_read: assert property (p_max_sub_read) else $error("Bad max subindex"); // [RULE_17]

  c_measure: cover property (meas_start ##[1:200] (o_shift != 32'h0));
  c_missed: cover property ($changed(o_miss));
  c_irq: cover property ($rose(irq));
  c_err: cover property ($rose(i_err));
endmodule

// file: design/sync_params_defs.svh
// Register offsets, reset values and timing constants of the sync parameter bank
`ifndef SYNC_PARAMS_DEFS_SVH
`define SYNC_PARAMS_DEFS_SVH

// Output side objects
`define OFF_OUT_SYNC_MODE 8'h00
`define OFF_OUT_CYCLE_TIME 8'h04
`define OFF_OUT_SHIFT_TIME 8'h08
`define OFF_OUT_SUPPORTED 8'h0c
`define OFF_OUT_MIN_CYCLE 8'h10
`define OFF_OUT_CALC_COPY 8'h14
`define OFF_OUT_COMMAND 8'h18
`define OFF_OUT_DELAY 8'h1c
`define OFF_OUT_MISSED 8'h20
`define OFF_OUT_EXCEEDED 8'h24
`define OFF_OUT_SHORT 8'h28
`define OFF_OUT_SYNC_ERR 8'h2c
`define OFF_OUT_MAX_SUB 8'h30
// Input side objects
`define OFF_IN_MAX_SUB 8'h40
`define OFF_IN_SYNC_MODE 8'h44
`define OFF_IN_CYCLE_TIME 8'h48
`define OFF_IN_SHIFT_TIME 8'h4c
`define OFF_IN_SUPPORTED 8'h50
`define OFF_IN_MIN_CYCLE 8'h54
`define OFF_IN_CALC_COPY 8'h58
`define OFF_IN_COMMAND 8'h5c
`define OFF_IN_DELAY 8'h60
`define OFF_IN_MISSED 8'h64
`define OFF_IN_EXCEEDED 8'h68
`define OFF_IN_SHORT 8'h6c
`define OFF_IN_SYNC_ERR 8'h70
// Interrupt registers
`define OFF_IRQ_STATUS 8'h80
`define OFF_IRQ_MASK 8'h84

// Reset values
`define RST_OUT_SYNC_MODE 16'h0001
`define RST_IN_SYNC_MODE 16'h0022
`define RST_SUPPORTED 16'hc007
`define RST_MAX_SUBINDEX 8'h20
`define RST_TIME 32'h0000_0000
`define RST_COUNT 16'h0000
`define RST_IRQ_MASK 8'h00

// Measurement command values
`define CMD_STOP 16'h0000
`define CMD_START 16'h0001

// Interrupt status field positions
`define IRQ_OUT_LSB 0
`define IRQ_IN_LSB 4

// Clock period in ns; the timestamp advances by this every clock
`define CLK_PERIOD_NS 32'h0000_0008

`endif

// file: design/sync_params_pkg.sv
// Types shared by the sync parameter bank
package sync_params_pkg;
  typedef enum logic [15:0] {
    MODE_FREE_RUN = 16'h0000,
    MODE_SM_EVENT = 16'h0001,
    MODE_DC_SYNC0 = 16'h0002,
    MODE_DC_SYNC1 = 16'h0003,
    MODE_OUT_SM_EVENT = 16'h0022
  } sync_mode_t;

  // Per-side events: missed, exceeded, shift short, sync error
  typedef logic [3:0] side_events_t;
endpackage

// file: tb/sync_master_model.sv
// Model of the fieldbus master side: cycle, sync and process-data events
`timescale 1ns/100ps

module sync_master_model #(
  parameter int PERIOD = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control from the bench
  input wire logic run,
  input wire logic sm_en,
  input wire logic act_en,
  input wire logic [7:0] gap,
  input wire logic [7:0] act,
  input wire logic [7:0] rdy,
  input wire logic [7:0] done,
  // Event pulses
  output logic sync0,
  output logic sync1,
  output logic sm_evt,
  output logic act_p,
  output logic rdy_p,
  output logic cyc_done
);
  logic [7:0] cnt_reg;
  logic on_reg;

  // Events stand still outside a burst; the period is the sync cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 8'h00;
      on_reg <= 1'b0;
    end else begin
      on_reg <= run;
      cnt_reg <= (!on_reg || cnt_reg == 8'(PERIOD - 1)) ? 8'h00 : cnt_reg + 8'h01;
    end
  end

  assign sync0 = on_reg && cnt_reg == 8'h00;
  assign sync1 = on_reg && cnt_reg == gap;
  assign sm_evt = on_reg && sm_en && cnt_reg == 8'h01;
  assign act_p = on_reg && act_en && cnt_reg == act;
  assign rdy_p = on_reg && cnt_reg == rdy;
  assign cyc_done = on_reg && cnt_reg == done;
endmodule

// file: tb/sync_params_bank_tb.sv
// Self-checking bench for the sync parameter bank
`timescale 1ns/100ps
`include "sync_params_defs.svh"

module sync_params_bank_tb;
  localparam int P = 20;
  logic clk, rstn, cyc, stb, we, op, run, sm_en, act_en;
  logic [7:0] adr, gap, act, rdy, done;
  logic [3:0] sel;
  logic [31:0] wdat, wb_dat_o, rd;
  logic wb_ack_o, s0, s1, sm, ap, rp, cd, meas, irq, odc, idc;
  int mismatches, samples_checked;
  logic [7:0] rst_adr[20] = '{8'h00, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24,
    8'h28, 8'h2c, 8'h30, 8'h40, 8'h44, 8'h50, 8'h54, 8'h5c, 8'h64, 8'h70, 8'h84, 8'h90};
  logic [31:0] rst_val[20] = '{32'h1, 32'hc007, 0, 0, 0, 0, 0, 0, 0, 0, 32'h20, 32'h20,
    32'h22, 32'hc007, 0, 0, 0, 0, 0, 0};
  logic [15:0] modes[5] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h22};

  sync_master_model #(.PERIOD(P)) mdl_u (.clk(clk), .rstn(rstn), .run(run), .sm_en(sm_en),
    .act_en(act_en), .gap(gap), .act(act), .rdy(rdy), .done(done), .sync0(s0), .sync1(s1),
    .sm_evt(sm), .act_p(ap), .rdy_p(rp), .cyc_done(cd));

  sync_params_bank dut_u (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sync0_evt(s0), .sync1_evt(s1), .op_state(op), .out_sm_evt(sm),
    .outputs_driven(ap), .out_data_ready(rp), .out_cycle_start(s0), .out_cycle_done(cd),
    .in_sm_evt(sm), .inputs_sampled(ap), .in_data_ready(rp), .in_cycle_start(s0),
    .in_cycle_done(cd), .measure_active(meas), .out_dc_mode(odc), .in_dc_mode(idc), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until ack is sampled high at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    rd = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 40) begin
      mismatches++;
      $display("ERROR %0t: no bus answer", $time);
      summarize();
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic burst(input int n);
    run <= 1'b1;
    repeat (n) @(posedge clk);
    run <= 1'b0;
    repeat (P) @(posedge clk);
  endtask

  task automatic reset_values();
    for (int i = 0; i < 20; i++) rdchk(rst_adr[i], rst_val[i]);
    chk(odc, 1'b0);
    chk(idc, 1'b0);
    bus(1'b1, `OFF_IN_SUPPORTED, 32'h0);
    rdchk(`OFF_IN_SUPPORTED, 32'hc007);
    bus(1'b1, `OFF_IN_MIN_CYCLE, 32'h55);
    rdchk(`OFF_IN_MIN_CYCLE, 32'h0);
  endtask

  task automatic mode_codes();
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, `OFF_IN_SYNC_MODE, {16'h0, modes[i]});
      rdchk(`OFF_IN_SYNC_MODE, {16'h0, modes[i]});
    end
    bus(1'b1, `OFF_IN_SYNC_MODE, 32'h5);
    rdchk(`OFF_IN_SYNC_MODE, 32'h22);
  endtask

  // Operational DC run with no SM events, no act pulses and late data
  task automatic fault_counters();
    bus(1'b1, `OFF_OUT_SYNC_MODE, 32'h2);
    bus(1'b1, `OFF_IN_SYNC_MODE, 32'h2);
    bus(1'b1, `OFF_OUT_CYCLE_TIME, 32'h10);
    bus(1'b1, `OFF_IN_CYCLE_TIME, 32'h10);
    rdchk(`OFF_IN_CYCLE_TIME, 32'h10);
    chk(odc, 1'b1);
    chk(idc, 1'b1);
    op <= 1'b1; sm_en <= 1'b0; act_en <= 1'b0;
    burst(3 * P);
    for (int s = 0; s < 2; s++) begin
      rdchk(8'(`OFF_OUT_MISSED + s * 8'h44), 32'h2);
      rdchk(8'(`OFF_OUT_EXCEEDED + s * 8'h44), 32'h3);
      rdchk(8'(`OFF_OUT_SHORT + s * 8'h44), 32'h3);
      rdchk(8'(`OFF_OUT_SYNC_ERR + s * 8'h44), 32'h1);
    end
    chk(irq, 1'b0);
    bus(1'b1, `OFF_IRQ_MASK, 32'h1);
    // A write lands at the ack edge, so its level outputs are looked at one edge later
    @(posedge clk);
    chk(irq, 1'b1);
    rdchk(`OFF_IRQ_STATUS, 32'hff);
    rdchk(`OFF_IRQ_STATUS, 32'h0);
    chk(irq, 1'b0);
  endtask

  task automatic measure(input logic [7:0] a, input logic [31:0] sh);
    act <= a;
    burst(2 * P);
    for (int s = 0; s < 2; s++) begin
      rdchk(8'(`OFF_OUT_SHIFT_TIME + s * 8'h44), sh);
      rdchk(8'(`OFF_OUT_DELAY + s * 8'h44), sh - 32'h20);
      rdchk(8'(`OFF_OUT_MIN_CYCLE + s * 8'h44), 32'h50);
    end
    rdchk(`OFF_OUT_CALC_COPY, 32'h48);
    rdchk(`OFF_IN_CALC_COPY, 32'h48 - sh);
  endtask

  task automatic measurement();
    op <= 1'b0; sm_en <= 1'b1; act_en <= 1'b1;
    bus(1'b1, `OFF_IN_COMMAND, {16'h0, `CMD_START});
    @(posedge clk);
    chk(meas, 1'b1);
    rdchk(`OFF_OUT_COMMAND, 32'h1);
    measure(8'h06, 32'h30);
    bus(1'b1, `OFF_OUT_COMMAND, {16'h0, `CMD_STOP});
    @(posedge clk);
    chk(meas, 1'b0);
    measure(8'h05, 32'h30);
    // Restart must drop the larger maxima from the first run
    bus(1'b1, `OFF_OUT_COMMAND, {16'h0, `CMD_START});
    measure(8'h05, 32'h28);
  endtask

  initial begin
    rstn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'hf; wdat = 32'h0;
    op = 1'b0; run = 1'b0; sm_en = 1'b0; act_en = 1'b0;
    gap = 8'h04; act = 8'h06; rdy = 8'h09; done = 8'h0a;
    mismatches = 0; samples_checked = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    reset_values();
    mode_codes();
    fault_counters();
    measurement();
    summarize();
  end
endmodule
